//--- logic/clb_bus_ctl.sv
// bus controller: line reads (burst or inhibited) and single writes
`timescale 1ns/1ns
module clb_bus_ctl
  import clb_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // request from the memory unit
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_line,
  input wire logic [1:0] req_size,
  input wire logic [31:0] req_addr,
  input wire logic [31:0] req_wdata,
  input wire logic [1:0] req_user,
  input wire logic [2:0] req_type,
  input wire logic [2:0] req_mod,
  input wire logic req_noncache,
  input wire logic req_altspace,
  // answers to the memory unit
  output logic rd_valid,
  output logic [31:0] rd_data,
  output logic [1:0] rd_index,
  output logic rd_nocache,
  output logic wr_done,
  // bus pins toward the slave
  output logic [31:0] addr,
  output logic [1:0] xfer_size,
  output logic rw,
  output logic [1:0] user_attr,
  output logic [2:0] access_type,
  output logic [2:0] access_modifier,
  output logic nocache_out_n,
  output logic cycle_begin_n,
  output logic cycle_active_n,
  output logic [31:0] data_o,
  output logic [3:0] data_oe,
  // bus pins from the slave
  input wire logic [31:0] data_i,
  input wire logic xfer_ack_n,
  input wire logic burst_refuse_n,
  input wire logic slave_nocache_n
);

  typedef struct packed {
    clb_state_e st;
    logic line;
    logic first;
    logic inhibited;
    logic [1:0] beat;
    logic nc_line;
    logic [31:0] addr;
    logic [1:0] size;
    logic rw;
    logic [1:0] user;
    logic [2:0] ttype;
    logic [2:0] tmod;
    logic nc_out;
    logic begin_n;
    logic active_n;
    logic [31:0] dout;
    logic [3:0] oe;
    logic rd_valid;
    logic [31:0] rd_data;
    logic [1:0] rd_index;
    logic rd_nc;
    logic wr_done;
  } clb_state_s;

  clb_state_s st_r;
  clb_state_s st_nxt;
  logic [3:0] lanes;
  logic ack;

  clb_lane_sel u_lanes (
    .size(st_r.size),
    .addr_lo(st_r.addr[1:0]),
    .lanes(lanes)
  );

  // slave runs on this same bus clock, so its pins are sampled directly;
  // a synchroniser would let one ack count for several beats
  assign ack = ~xfer_ack_n;
  // new request only accepted while no beat is pending
  assign req_ready = (st_r.st == CLB_IDLE) || (st_r.st == CLB_RELEASE);

  // next-state logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.rd_valid = 1'b0;
    st_nxt.wr_done = 1'b0;
    case (st_r.st)
      CLB_IDLE, CLB_RELEASE: begin
        st_nxt.oe = CLB_LANES_NONE;
        st_nxt.begin_n = 1'b1;
        if (req_valid) begin
          // attributes driven in the first clock
          st_nxt.addr = req_addr;
          st_nxt.line = req_line;
          st_nxt.size = req_line ? CLB_SIZE_LINE : req_size;
          st_nxt.rw = req_line; // write drives read/write low
          st_nxt.user = req_user;
          st_nxt.ttype = req_type;
          st_nxt.tmod = req_mod;
          // only noncachable or alternate space writes
          st_nxt.nc_out = req_noncache | (~req_line & req_altspace);
          st_nxt.begin_n = 1'b0;
          st_nxt.active_n = 1'b0;
          st_nxt.dout = req_wdata;
          st_nxt.first = 1'b1;
          st_nxt.inhibited = 1'b0;
          st_nxt.beat = 2'h0;
          st_nxt.st = CLB_START;
        end else begin
          st_nxt.active_n = 1'b1;
          st_nxt.st = CLB_IDLE;
        end
      end
      CLB_START: begin
        st_nxt.begin_n = 1'b1;
        if (!st_r.rw) begin
          st_nxt.oe = lanes;
        end
        st_nxt.st = CLB_DATA;
      end
      CLB_DATA: begin
        // wait states: keep sampling on each edge, latched data dropped
        if (ack) begin
          if (!st_r.rw) begin
            // write terminates, slave nocache ignored
            st_nxt.wr_done = 1'b1;
            st_nxt.oe = CLB_LANES_NONE;
            st_nxt.st = CLB_RELEASE;
          end else begin
            st_nxt.rd_valid = 1'b1;
            st_nxt.rd_data = data_i;
            // inhibited cycles already carry the bumped address
            st_nxt.rd_index = st_r.inhibited ? st_r.addr[3:2]
                                             : st_r.addr[3:2] + st_r.beat;
            if (st_r.first) begin
              // refuse and nocache judged on first beat only
              st_nxt.nc_line = ~slave_nocache_n;
              st_nxt.inhibited = st_r.line & ~burst_refuse_n;
            end
            st_nxt.rd_nc = st_r.first ? ~slave_nocache_n : st_r.nc_line;
            st_nxt.first = 1'b0;
            st_nxt.beat = st_r.beat + 2'h1;
            if (!st_r.line || st_r.beat == CLB_LAST_BEAT) begin
              st_nxt.st = CLB_RELEASE;
            end else if (st_r.first ? ~burst_refuse_n : st_r.inhibited) begin
              // separate long reads, processor bumps A3:A2
              st_nxt.addr[3:2] = st_r.addr[3:2] + 2'h1;
              st_nxt.size = CLB_SIZE_LONG;
              st_nxt.begin_n = 1'b0;
              st_nxt.st = CLB_START;
            end else begin
              // burst beat, address held
              st_nxt.st = CLB_DATA;
            end
          end
        end
      end
      default: st_nxt.st = CLB_IDLE;
    endcase
  end

  // state register; pins idle high, bus released
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.st <= CLB_IDLE;
      st_r.rw <= 1'b1;
      st_r.begin_n <= 1'b1;
      st_r.active_n <= 1'b1;
      st_r.addr <= CLB_ADDR_RST;
      st_r.dout <= CLB_DATA_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign rd_valid = st_r.rd_valid;
  assign rd_data = st_r.rd_data;
  assign rd_index = st_r.rd_index;
  assign rd_nocache = st_r.rd_nc;
  assign wr_done = st_r.wr_done;
  assign addr = st_r.addr;
  assign xfer_size = st_r.size;
  assign rw = st_r.rw;
  assign user_attr = st_r.user;
  assign access_type = st_r.ttype;
  assign access_modifier = st_r.tmod;
  assign nocache_out_n = ~st_r.nc_out;
  assign cycle_begin_n = st_r.begin_n;
  assign cycle_active_n = st_r.active_n;
  assign data_o = st_r.dout;
  assign data_oe = st_r.oe;

endmodule // clb_bus_ctl

//--- logic/clb_pkg.sv
// constants and types for the processor line-read and write bus controller
// Functional notes
// - sample ack, refuse, nocache, data at C2
// - no ack: drop data, wait, resample
// - first ack forwards data and nocache level
// - burst allowed continues line from clock three
// - burst refused: three long reads, bump A3:A2
// - burst five clocks, inhibited eight clocks
// - hold address in burst; slave advances A3:A2
// - beats three and four like beat two
// - keep cycle_active if next cycle ready
// - ignore slave nocache during writes
// - single writes for listed uncacheable cases
// - drive address, attributes, read/write low
// - nocache out for noncachable or alternate space; alternate space only on writes
// - assert begin and active in first clock
// - drop begin, drive selected lanes second clock
// - end write on ack else wait
// - release data drivers after write ends
// - burst refuse looked at first beat only
package clb_pkg;

  // bus cycle phases
  typedef enum logic [2:0] {
    CLB_IDLE,
    CLB_START,
    CLB_DATA,
    CLB_RELEASE
  } clb_state_e;

  // transfer sizes on xfer_size
  localparam logic [1:0] CLB_SIZE_LONG = 2'h0;
  localparam logic [1:0] CLB_SIZE_BYTE = 2'h1;
  localparam logic [1:0] CLB_SIZE_WORD = 2'h2;
  localparam logic [1:0] CLB_SIZE_LINE = 2'h3;

  // index of the last beat in one line
  localparam logic [1:0] CLB_LAST_BEAT = 2'h3;
  // reset values of the bus pins
  localparam logic [31:0] CLB_ADDR_RST = 32'h0000_0000;
  localparam logic [31:0] CLB_DATA_RST = 32'h0000_0000;
  localparam logic [3:0] CLB_LANES_NONE = 4'h0;

endpackage

//--- logic/clb_lane_sel.sv
// byte lane enables for a single write from size and low address
`timescale 1ns/1ns
module clb_lane_sel
  import clb_pkg::*;
(
  // transfer description
  input wire logic [1:0] size,
  input wire logic [1:0] addr_lo,
  // lane enables, bit 3 is the d31..d24 lane
  output logic [3:0] lanes
);

  // byte and word pick lanes from the offset, long and line use all four
  always_comb begin
    case (size)
      CLB_SIZE_BYTE: lanes = 4'h8 >> addr_lo;
      CLB_SIZE_WORD: lanes = addr_lo[1] ? 4'h3 : 4'hc;
      default: lanes = 4'hf;
    endcase
  end

endmodule // clb_lane_sel

//--- test/clb_bus_ctl_chk.sv
// pin checker for the bus controller
`timescale 1ns/1ns
module clb_bus_ctl_chk
  import clb_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // request side
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_line,
  input wire logic req_noncache,
  input wire logic req_altspace,
  input wire logic rd_valid,
  input wire logic wr_done,
  // bus pins
  input wire logic [31:0] addr,
  input wire logic [1:0] xfer_size,
  input wire logic rw,
  input wire logic nocache_out_n,
  input wire logic cycle_begin_n,
  input wire logic cycle_active_n,
  input wire logic [3:0] data_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic take;
  // request accepted at this edge
  assign take = req_valid && req_ready;
  a_begin_single: assert property ($fell(cycle_begin_n) |=> cycle_begin_n)
    else $error("begin longer than one clock");
  a_begin_active: assert property (!cycle_begin_n |-> !cycle_active_n)
    else $error("begin without active");
  a_write_start: assert property ((take && !req_line) |=>
    !cycle_begin_n && !rw &&
    nocache_out_n == !($past(req_noncache) || $past(req_altspace)))
    else $error("write start pins wrong");
  a_write_lanes: assert property ((!cycle_begin_n && !rw) |=>
    cycle_begin_n && data_oe != CLB_LANES_NONE)
    else $error("write lanes not driven");
  a_data_release: assert property (wr_done |-> ##[0:1] data_oe == 4'h0)
    else $error("data lanes not released");
  a_burst_hold: assert property ((rw && xfer_size == CLB_SIZE_LINE &&
    cycle_begin_n) ##1 cycle_begin_n |-> $stable(addr))
    else $error("address moved in burst");
  a_cycle_bound: assert property ($fell(cycle_begin_n) |->
    ##[1:40] (rd_valid || wr_done))
    else $error("cycle never ended");
  a_active_keep: assert property ((take && !cycle_active_n) |=>
    !cycle_active_n)
    else $error("active dropped between cycles");
  a_active_drop: assert property ((req_ready && !req_valid) [*2] |->
    cycle_active_n)
    else $error("active held while idle");
  // main scenarios reached
  c_line: cover property (rd_valid && xfer_size == CLB_SIZE_LINE);
  c_write: cover property (wr_done);
  c_refused: cover property (!cycle_begin_n && rw && xfer_size == CLB_SIZE_LONG);
endmodule // clb_bus_ctl_chk

bind clb_bus_ctl clb_bus_ctl_chk u_chk (.*);

//--- test/clb_slave_model.sv
// behavioural memory slave on the far side of the bus
`timescale 1ns/1ns
module clb_slave_model
  import clb_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // bus from the controller
  input wire logic cycle_begin_n,
  input wire logic [1:0] xfer_size,
  input wire logic [31:0] addr,
  input wire logic [31:0] data_o,
  input wire logic [3:0] data_oe,
  // behaviour chosen by the bench
  input wire logic refuse,
  input wire logic nocache,
  input wire logic [1:0] wait_cy,
  // answers and last write seen
  output logic [31:0] data_i,
  output logic xfer_ack_n,
  output logic burst_refuse_n,
  output logic slave_nocache_n,
  output logic [31:0] got_data,
  output logic [3:0] got_lanes
);
  int beats;
  logic [1:0] idx;
  // begin seen mid-clock; ack stands one clock per beat, sampled at its end
  initial begin
    {xfer_ack_n, burst_refuse_n, slave_nocache_n} = 3'h7;
    data_i = 32'h0;
    forever begin
      @(negedge clock);
      if (!rst && !cycle_begin_n) begin
        beats = (xfer_size == CLB_SIZE_LINE && !refuse) ? 4 : 1;
        @(posedge clock);
        for (int b = 0; b < beats; b++) begin
          if (wait_cy != 2'h0) begin
            {xfer_ack_n, burst_refuse_n, slave_nocache_n} <= 3'h7;
            repeat (wait_cy) @(posedge clock);
          end
          idx = addr[3:2] + 2'(b);
          xfer_ack_n <= 1'b0;
          burst_refuse_n <= (b == 0) ? !refuse : 1'b0;
          slave_nocache_n <= !nocache;
          data_i <= 32'h1000_0000 + 32'(idx);
          @(posedge clock);
          got_data <= data_o;
          got_lanes <= data_oe;
        end
        {xfer_ack_n, burst_refuse_n, slave_nocache_n} <= 3'h7;
        data_i <= ~data_i; // released bus must not keep old data
      end
    end
  end
endmodule // clb_slave_model

//--- test/test_clb_bus_ctl.sv
// self-checking bench for the bus controller with a slave model
`timescale 1ns/1ns
module test_clb_bus_ctl;
  import clb_pkg::*;
  // fl: noncache, altspace, refuse, slave nocache
  typedef struct packed {
    logic line; logic [1:0] size; logic [31:0] addr; logic [31:0] wdata;
    logic [3:0] fl; logic [1:0] wt; logic dup; logic [3:0] lanes; logic nco;
  } clb_row_s;
  logic clock, rst, req_valid, req_ready, req_line, req_noncache;
  logic req_altspace, rd_valid, rd_nocache, wr_done, rw, nocache_out_n;
  logic cycle_begin_n, cycle_active_n, xfer_ack_n, burst_refuse_n;
  logic slave_nocache_n, refuse, nocache;
  logic [1:0] req_size, req_user, rd_index, xfer_size, user_attr, wait_cy;
  logic [2:0] req_type, req_mod, access_type, access_modifier;
  logic [3:0] data_oe, got_lanes;
  logic [31:0] req_addr, req_wdata, rd_data, addr, data_o, data_i, got_data;
  int n_fail = 0;
  int compares = 0;
  clb_row_s rows [7] = '{
    '{1'h0, CLB_SIZE_BYTE, 32'h1001, 32'h1122_3344, 4'h1, 2'h0, 1'h1, 4'h4, 1'h1},
    '{1'h0, CLB_SIZE_BYTE, 32'h2003, 32'ha5a5_a5a5, 4'h4, 2'h1, 1'h0, 4'h1, 1'h0},
    '{1'h0, CLB_SIZE_WORD, 32'h3002, 32'h5566_7788, 4'h8, 2'h2, 1'h0, 4'h3, 1'h0},
    '{1'h0, CLB_SIZE_LONG, 32'h4000, 32'h0f1e_2d3c, 4'h0, 2'h0, 1'h0, 4'hf, 1'h1},
    '{1'h1, CLB_SIZE_LINE, 32'h5008, 32'h0, 4'h1, 2'h0, 1'h0, 4'h0, 1'h1},
    '{1'h1, CLB_SIZE_LINE, 32'h6007, 32'h0, 4'h0, 2'h2, 1'h0, 4'h0, 1'h1},
    '{1'h1, CLB_SIZE_LINE, 32'h700c, 32'h0, 4'h3, 2'h1, 1'h0, 4'h0, 1'h1}};
  clb_bus_ctl DUT (.*);
  clb_slave_model u_slv (.*);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one request; a dup row is offered twice so it is taken back to back
  task automatic run_row(input clb_row_s r);
    int k, nbeg, nrd;
    logic [1:0] idx;
    logic [31:0] m;
    nbeg = 0;
    nrd = 0;
    idx = r.addr[3:2];
    m = {{8{r.lanes[3]}}, {8{r.lanes[2]}}, {8{r.lanes[1]}}, {8{r.lanes[0]}}};
    @(posedge clock);
    req_valid <= 1'b1;
    {req_line, req_size, req_addr, req_wdata} <= {r.line, r.size, r.addr, r.wdata};
    {req_noncache, req_altspace, refuse, nocache, wait_cy} <= {r.fl, r.wt};
    {req_user, req_type, req_mod} <= r.wdata[7:0];
    repeat (r.dup ? 2 : 1) begin
      k = 0;
      do @(negedge clock); while (req_ready !== 1'b1 && ++k < 100);
      if (k >= 100) begin
        n_fail++;
        print_verdict;
      end
      @(posedge clock);
    end
    req_valid <= 1'b0;
    for (k = 0; k < 200; k++) begin
      @(negedge clock);
      if (cycle_begin_n === 1'b0) nbeg++;
      if (rd_valid === 1'b1) begin
        check({rd_index, rd_nocache, rd_data}, {idx, r.fl[0], 32'h1000_0000 + 32'(idx)});
        idx++;
        nrd++;
      end
      if (wr_done === 1'b1 || nrd == 4) break;
    end
    if (k == 200) begin
      n_fail++;
      print_verdict;
    end
    check(nbeg, r.line ? (r.fl[1] ? 4 : 1) : 1);
    check(nocache_out_n, r.nco);
    if (!r.line) check({got_lanes, got_data & m}, {r.lanes, r.wdata & m});
  endtask
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    {req_line, req_size, req_addr, req_wdata, req_user, req_type} = '0;
    {req_mod, req_noncache, req_altspace, refuse, nocache, wait_cy} = '0;
    repeat (6) @(posedge clock);
    check({cycle_begin_n, cycle_active_n, nocache_out_n, rw, data_oe}, 8'hf0);
    rst <= 1'b0;
    foreach (rows[i]) run_row(rows[i]);
    // once idle the controller lets go of active and the data lanes
    repeat (3) @(negedge clock);
    check({cycle_active_n, data_oe}, 5'h10);
    print_verdict;
  end
endmodule // test_clb_bus_ctl
